// ### verilog/pcd_primary_cmd_decode.sv
// primary side command decoder of the bridge
`timescale 1ns/1ps
`include "pcd_regs.svh"

module pcd_primary_cmd_decode import pcd_pkg::*; #(
  parameter logic [31:0] CSR_MEM_SIZE = 32'h0000_1000,
  parameter logic [31:0] CSR_IO_SIZE  = 32'h0000_0100
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // primary address phase
  input  wire logic        addr_valid_i,
  input  wire logic [3:0]  primary_cmd_byte_en_n_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        primary_config_select_i,
  // bridge configuration
  input  wire logic        pcix_mode_i,
  input  wire logic [7:0]  sec_bus_i,
  input  wire logic [7:0]  sub_bus_i,
  input  wire logic [63:0] mem_base_i,
  input  wire logic [63:0] mem_limit_i,
  input  wire logic [31:0] io_base_i,
  input  wire logic [31:0] io_limit_i,
  input  wire logic [31:0] csr_mem_base_i,
  input  wire logic [31:0] csr_io_base_i,
  // decision
  output logic             valid_o,
  output logic             claim_o,
  output logic             forward_o,
  output logic             local_o,
  output logic             dac_o,
  output pcd_kind_e        kind_o,
  output logic [3:0]       out_cmd_o,
  output logic [63:0]      out_addr_o
);

  // ****************
  // decode
  // ****************
  logic [3:0]  cmd_w;
  logic        ph_w;
  logic [1:0]  ctype_w;
  logic [7:0]  bus_w;
  logic [4:0]  dev_w;
  logic [2:0]  fn_w;
  logic        sec_hit_w;
  logic        sub_hit_w;
  logic        spc_w;
  pcd_state_e  state_reg;
  pcd_state_e  state_next;

  assign cmd_w     = ~primary_cmd_byte_en_n_i;
  assign ph_w      = (state_reg == ST_ADDR) && addr_valid_i;
  assign ctype_w   = addr_i[`PCD_CFG_TYPE_MSB:`PCD_CFG_TYPE_LSB];
  assign bus_w     = addr_i[`PCD_CFG_BUS_MSB:`PCD_CFG_BUS_LSB];
  assign dev_w     = addr_i[`PCD_CFG_DEV_MSB:`PCD_CFG_DEV_LSB];
  assign fn_w      = addr_i[`PCD_CFG_FN_MSB:`PCD_CFG_FN_LSB];
  assign sec_hit_w = (bus_w == sec_bus_i);
  assign sub_hit_w = (bus_w > sec_bus_i) && (bus_w <= sub_bus_i);
  assign spc_w     = (dev_w == `PCD_SPC_DEV) && (fn_w == `PCD_SPC_FN);

  logic [31:0] lo_reg;
  logic [31:0] lo_next;
  logic        valid_next;
  logic        claim_next;
  logic        fwd_next;
  logic        local_next;
  logic        dac_next;
  pcd_kind_e   kind_next;
  logic [3:0]  cmd_next;
  logic [63:0] addr_next;

  always_comb begin
    logic        dec;
    logic        dual;
    logic [63:0] a;
    logic        mem_in;
    logic        csr_m;
    logic        io_in;
    logic        csr_io;
    logic        wr;
    dec        = 1'b0;
    dual       = 1'b0;
    mem_in     = 1'b0;
    csr_m      = 1'b0;
    io_in      = 1'b0;
    csr_io     = 1'b0;
    wr         = 1'b0;
    a          = {32'h0, addr_i};
    state_next = state_reg;
    lo_next    = lo_reg;
    unique case (state_reg)
      ST_ADDR: begin
        if (addr_valid_i) begin
          if (cmd_w == `PCD_CMD_DAC) begin
            lo_next    = addr_i;
            state_next = ST_DAC_HI;
          end else begin
            dec = 1'b1;
          end
        end
      end
      ST_DAC_HI: begin
        a          = {addr_i, lo_reg};
        dec        = 1'b1;
        dual       = 1'b1;
        state_next = ST_ADDR;
      end
    endcase
    mem_in     = (a >= mem_base_i) && (a <= mem_limit_i);
    csr_m      = (a[63:32] == 32'h0) && (a[31:0] >= csr_mem_base_i)
                 && ((a[31:0] - csr_mem_base_i) < CSR_MEM_SIZE);
    io_in      = (addr_i >= io_base_i) && (addr_i <= io_limit_i);
    csr_io     = (addr_i >= csr_io_base_i)
                 && ((addr_i - csr_io_base_i) < CSR_IO_SIZE);
    valid_next = dec;
    claim_next = 1'b0;
    fwd_next   = 1'b0;
    local_next = 1'b0;
    dac_next   = dual;
    kind_next  = K_NONE;
    cmd_next   = `PCD_RST_CMD;
    addr_next  = a;
    if (dec) begin
      unique case (cmd_w)
        `PCD_CMD_CFG_RD, `PCD_CMD_CFG_WR: begin
          if (!dual && primary_config_select_i) begin
            if (ctype_w == `PCD_CFG_TYPE0) begin
              local_next = 1'b1;
              kind_next  = K_CFG_LOCAL;
              cmd_next   = cmd_w;
            end else if (ctype_w == `PCD_CFG_TYPE1) begin
              if (sec_hit_w && cmd_w == `PCD_CMD_CFG_WR && spc_w) begin
                fwd_next  = 1'b1;
                kind_next = K_SPECIAL;
                cmd_next  = `PCD_CMD_SPECIAL;
              end else if (sec_hit_w) begin
                fwd_next  = 1'b1;
                kind_next = K_CFG_T0;
                cmd_next  = cmd_w;
                addr_next = {a[63:2], `PCD_CFG_TYPE0};
              end else if (sub_hit_w) begin
                fwd_next  = 1'b1;
                kind_next = K_CFG_T1;
                cmd_next  = cmd_w;
              end
            end
          end
        end
        `PCD_CMD_IO_RD, `PCD_CMD_IO_WR: begin
          if (!dual && io_in) begin
            fwd_next  = 1'b1;
            kind_next = K_IO;
            cmd_next  = cmd_w;
          end else if (!dual && csr_io) begin
            local_next = 1'b1;
            kind_next  = K_IO_LOCAL;
            cmd_next   = cmd_w;
          end
        end
        `PCD_CMD_MRM: begin
          if (pcix_mode_i) begin
            if (sec_hit_w || sub_hit_w) begin
              fwd_next  = 1'b1;
              kind_next = K_SPLIT;
              cmd_next  = `PCD_CMD_MRM;
            end
          end else begin
            cmd_next = `PCD_CMD_MEM_RD;
          end
        end
        `PCD_CMD_MEM_RD:   cmd_next = `PCD_CMD_MEM_RD;
        `PCD_CMD_MEM_WR:   cmd_next = `PCD_CMD_MEM_WR;
        `PCD_CMD_MRL:      cmd_next = pcix_mode_i ? `PCD_CMD_MRL : `PCD_CMD_MEM_RD;
        `PCD_CMD_MWI:      cmd_next = pcix_mode_i ? `PCD_CMD_MWI : `PCD_CMD_MEM_WR;
        `PCD_CMD_ALIAS_RB: cmd_next = pcix_mode_i ? `PCD_CMD_MRL : `PCD_RST_CMD;
        `PCD_CMD_ALIAS_WB: cmd_next = pcix_mode_i ? `PCD_CMD_MWI : `PCD_RST_CMD;
        default: ;
      endcase
      if (kind_next == K_NONE && cmd_next != `PCD_RST_CMD) begin
        wr = (cmd_next == `PCD_CMD_MEM_WR) || (cmd_next == `PCD_CMD_MWI);
        if (mem_in) begin
          fwd_next = 1'b1;
          unique case (cmd_next)
            `PCD_CMD_MEM_RD: kind_next = K_MEM_RD;
            `PCD_CMD_MEM_WR: kind_next = K_MEM_WR;
            `PCD_CMD_MRL:    kind_next = K_MRB;
            default:         kind_next = K_MWB;
          endcase
        end else if (csr_m) begin
          local_next = 1'b1;
          kind_next  = K_MEM_LOCAL;
          cmd_next   = wr ? `PCD_CMD_MEM_WR : `PCD_CMD_MEM_RD;
        end else begin
          cmd_next = `PCD_RST_CMD;
        end
      end
      claim_next = fwd_next | local_next;
      if (!fwd_next) begin
        cmd_next = local_next ? cmd_next : `PCD_RST_CMD;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg  <= ST_ADDR;
      lo_reg     <= 32'h0;
      valid_o    <= 1'b0;
      claim_o    <= 1'b0;
      forward_o  <= 1'b0;
      local_o    <= 1'b0;
      dac_o      <= 1'b0;
      kind_o     <= K_NONE;
      out_cmd_o  <= `PCD_RST_CMD;
      out_addr_o <= `PCD_RST_ADDR;
    end else begin
      state_reg  <= state_next;
      lo_reg     <= lo_next;
      valid_o    <= valid_next;
      claim_o    <= claim_next;
      forward_o  <= fwd_next;
      local_o    <= local_next;
      dac_o      <= dac_next;
      kind_o     <= kind_next;
      out_cmd_o  <= cmd_next;
      out_addr_o <= addr_next;
    end
  end

  // ****************
  // checks
  // ****************
  sequence s_cfg(logic [3:0] c, logic [1:0] t);
    ph_w && cmd_w == c && ctype_w == t;
  endsequence

  sequence s_dac;
    ph_w && cmd_w == `PCD_CMD_DAC ##1 1'b1;
  endsequence

  a_cfg0_nosel: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_cfg(`PCD_CMD_CFG_RD, `PCD_CFG_TYPE0) and !primary_config_select_i
    |=> valid_o && !claim_o)
    else $error("type 0 read claimed without select");

  a_cfg0_local: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_cfg(`PCD_CMD_CFG_RD, `PCD_CFG_TYPE0) and primary_config_select_i
    |=> claim_o && local_o && !forward_o && kind_o == K_CFG_LOCAL)
    else $error("type 0 read not kept local");

  a_cfg1_nosel: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_cfg(`PCD_CMD_CFG_RD, `PCD_CFG_TYPE1) and !primary_config_select_i
    |=> !claim_o)
    else $error("type 1 read claimed without select");

  a_cfg1_conv: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_cfg(`PCD_CMD_CFG_RD, `PCD_CFG_TYPE1) and primary_config_select_i
      and sec_hit_w
    |=> forward_o && out_cmd_o == `PCD_CMD_CFG_RD && out_addr_o[1:0] == 2'h0)
    else $error("type 1 read to secondary not converted");

  a_cfg1_sub: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_cfg(`PCD_CMD_CFG_RD, `PCD_CFG_TYPE1) and primary_config_select_i
      and sub_hit_w
    |=> forward_o && out_addr_o[31:0] == $past(addr_i))
    else $error("type 1 read to subordinate altered");

  a_cfgw_local: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_cfg(`PCD_CMD_CFG_WR, `PCD_CFG_TYPE0)
    |=> local_o == $past(primary_config_select_i) && !forward_o)
    else $error("type 0 write misdecoded");

  a_special_cyc: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_cfg(`PCD_CMD_CFG_WR, `PCD_CFG_TYPE1) and primary_config_select_i
      and sec_hit_w and spc_w
    |=> forward_o && out_cmd_o == `PCD_CMD_SPECIAL)
    else $error("special request not issued as special cycle");

  a_mrm_conv: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    ph_w && cmd_w == `PCD_CMD_MRM && !pcix_mode_i && claim_next
    |=> out_cmd_o == `PCD_CMD_MEM_RD)
    else $error("read multiple not mapped to memory read");

  a_dac_order: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_dac |=> valid_o && dac_o && out_addr_o[31:0] == $past(addr_i, 2)
      && out_addr_o[63:32] == $past(addr_i))
    else $error("dual address words out of order");

  a_rsvd_quiet: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    ph_w && (cmd_w == 4'h4 || cmd_w == 4'h5 || cmd_w == 4'h0)
    |=> valid_o && !claim_o && !forward_o && !local_o)
    else $error("reserved command claimed");

endmodule : pcd_primary_cmd_decode

// ### verilog/pcd_regs.svh
// constants for the primary command decoder
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH
// ****************
// command codes (active high)
// ****************
`define PCD_CMD_SPECIAL  4'h1
`define PCD_CMD_IO_RD    4'h2
`define PCD_CMD_IO_WR    4'h3
`define PCD_CMD_MEM_RD   4'h6
`define PCD_CMD_MEM_WR   4'h7
`define PCD_CMD_ALIAS_RB 4'h8
`define PCD_CMD_ALIAS_WB 4'h9
`define PCD_CMD_CFG_RD   4'hA
`define PCD_CMD_CFG_WR   4'hB
`define PCD_CMD_MRM      4'hC
`define PCD_CMD_DAC      4'hD
`define PCD_CMD_MRL      4'hE
`define PCD_CMD_MWI      4'hF
// ****************
// config address fields
// ****************
`define PCD_CFG_TYPE_LSB 0
`define PCD_CFG_TYPE_MSB 1
`define PCD_CFG_TYPE0    2'h0
`define PCD_CFG_TYPE1    2'h1
`define PCD_CFG_FN_LSB   8
`define PCD_CFG_FN_MSB   10
`define PCD_CFG_DEV_LSB  11
`define PCD_CFG_DEV_MSB  15
`define PCD_CFG_BUS_LSB  16
`define PCD_CFG_BUS_MSB  23
`define PCD_SPC_DEV      5'h1F
`define PCD_SPC_FN       3'h7
// ****************
// reset values
// ****************
`define PCD_RST_ADDR     64'h0
`define PCD_RST_CMD      4'h0
`endif

// ### verilog/pcd_pkg.sv
// types for the primary command decoder
package pcd_pkg;
  typedef enum logic {ST_ADDR, ST_DAC_HI} pcd_state_e;
  typedef enum logic [3:0] {
    K_NONE, K_CFG_LOCAL, K_CFG_T0, K_CFG_T1, K_SPECIAL, K_MEM_RD,
    K_MEM_WR, K_MRB, K_MWB, K_SPLIT, K_IO, K_MEM_LOCAL, K_IO_LOCAL
  } pcd_kind_e;
endpackage : pcd_pkg

// ### sim/pcd_initiator_model.sv
// primary bus initiator model that presents address phases
`timescale 1ns/1ps
`include "pcd_regs.svh"
module pcd_initiator_model (
  // clock
  input  wire logic        clk_i,
  // address phase
  output logic             addr_valid_o,
  output logic [3:0]       cmd_n_o,
  output logic [31:0]      ad_o,
  output logic             config_select_o
);
  initial begin
    addr_valid_o = 1'b0;
    cmd_n_o = 4'hF;
    ad_o = 32'h0;
    config_select_o = 1'b0;
  end
  // ****************
  // released command and address lines show the inverse of the last value; valid and select drop low
  // ****************
  task automatic release_bus();
    addr_valid_o = 1'b0;
    cmd_n_o = ~cmd_n_o;
    ad_o = ~ad_o;
    config_select_o = 1'b0;
  endtask : release_bus
  task automatic phase(input logic [3:0] code, input logic [31:0] a, input logic v,
                       input logic sel);
    @(posedge clk_i);
    #2;
    addr_valid_o = v;
    cmd_n_o = ~code;
    ad_o = a;
    config_select_o = sel;
  endtask : phase
  task automatic issue(input logic [3:0] code, input logic [31:0] a, input logic sel);
    phase(code, a, 1'b1, sel);
    @(posedge clk_i);
    #2;
    release_bus();
  endtask : issue
  task automatic issue_dac(input logic [3:0] code, input logic [31:0] hi,
                           input logic [31:0] lo);
    phase(`PCD_CMD_DAC, lo, 1'b1, 1'b0);
    phase(code, hi, 1'b0, 1'b0);
    @(posedge clk_i);
    #2;
    release_bus();
  endtask : issue_dac
endmodule : pcd_initiator_model

// ### sim/pcd_primary_cmd_decode_tb.sv
// self-checking bench for the primary command decoder
`timescale 1ns/1ps
module pcd_primary_cmd_decode_tb import pcd_pkg::*;;
  logic clk = 1'b0;
  logic rstn, av, sel, pcix, vld, clm, fwd, loc, dac;
  logic [3:0] cmd_n, ocmd;
  logic [31:0] ad, io_b, io_l, cm_b, ci_b;
  logic [7:0] sec, sub;
  logic [63:0] m_b, m_l, oadr;
  pcd_kind_e kind;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  pcd_initiator_model i_init (.clk_i(clk), .addr_valid_o(av), .cmd_n_o(cmd_n), .ad_o(ad),
    .config_select_o(sel));
  pcd_primary_cmd_decode i_dut (.clk_i(clk), .rstn_i(rstn), .addr_valid_i(av),
    .primary_cmd_byte_en_n_i(cmd_n), .addr_i(ad), .primary_config_select_i(sel),
    .pcix_mode_i(pcix), .sec_bus_i(sec), .sub_bus_i(sub), .mem_base_i(m_b),
    .mem_limit_i(m_l), .io_base_i(io_b), .io_limit_i(io_l), .csr_mem_base_i(cm_b),
    .csr_io_base_i(ci_b), .valid_o(vld), .claim_o(clm), .forward_o(fwd), .local_o(loc),
    .dac_o(dac), .kind_o(kind), .out_cmd_o(ocmd), .out_addr_o(oadr));
  // ****************
  // compare helpers
  // ****************
  task automatic chk_dec(input logic [12:0] exp);
    cmp_count++;
    if ({vld, clm, fwd, loc, dac, kind, ocmd} !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time,
               {vld, clm, fwd, loc, dac, kind, ocmd}, exp);
    end
  endtask : chk_dec
  task automatic chk_addr(input logic [63:0] exp);
    cmp_count++;
    if (oadr !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, oadr, exp);
    end
  endtask : chk_addr
  function automatic logic [12:0] dx(logic f, logic l, pcd_kind_e k, logic [3:0] c);
    return {1'b1, f | l, f, l, 1'b0, k, c};
  endfunction : dx
  function automatic logic [31:0] cf(logic [7:0] b, logic [4:0] d, logic [2:0] f);
    return {8'h00, b, d, f, 6'h04, 2'b01};
  endfunction : cf
  task automatic try(input logic [3:0] c, input logic [31:0] a, input logic s,
                     input logic [12:0] exp);
    i_init.issue(c, a, s);
    chk_dec(exp);
  endtask : try
  // ****************
  // scenarios
  // ****************
  task automatic t_cfg_read();
    try(4'hA, 32'h0000_0010, 1'b1, dx(0, 1, K_CFG_LOCAL, 4'hA));
    try(4'hA, 32'h0000_0010, 1'b0, dx(0, 0, K_NONE, 4'h0));
    try(4'hA, cf(8'h05, 5'h02, 3'h1), 1'b1, dx(1, 0, K_CFG_T0, 4'hA));
    chk_addr({32'h0, cf(8'h05, 5'h02, 3'h1) & 32'hFFFF_FFFC});
    try(4'hA, cf(8'h09, 5'h03, 3'h0), 1'b1, dx(1, 0, K_CFG_T1, 4'hA));
    chk_addr({32'h0, cf(8'h09, 5'h03, 3'h0)});
    try(4'hA, cf(8'h05, 5'h02, 3'h1), 1'b0, dx(0, 0, K_NONE, 4'h0));
    try(4'hA, cf(8'h0A, 5'h02, 3'h1), 1'b1, dx(0, 0, K_NONE, 4'h0));
  endtask : t_cfg_read
  task automatic t_cfg_write();
    try(4'hB, 32'h0000_0020, 1'b1, dx(0, 1, K_CFG_LOCAL, 4'hB));
    try(4'hB, 32'h0000_0020, 1'b0, dx(0, 0, K_NONE, 4'h0));
    try(4'hB, cf(8'h05, 5'h04, 3'h0), 1'b1, dx(1, 0, K_CFG_T0, 4'hB));
    try(4'hB, cf(8'h05, 5'h1F, 3'h7), 1'b1, dx(1, 0, K_SPECIAL, 4'h1));
    try(4'hB, cf(8'h07, 5'h1F, 3'h7), 1'b1, dx(1, 0, K_CFG_T1, 4'hB));
    chk_addr({32'h0, cf(8'h07, 5'h1F, 3'h7)});
  endtask : t_cfg_write
  task automatic t_aliases();
    pcix = 1'b0;
    try(4'hC, 32'h8000_0100, 1'b0, dx(1, 0, K_MEM_RD, 4'h6));
    try(4'hE, 32'h8000_0200, 1'b0, dx(1, 0, K_MEM_RD, 4'h6));
    try(4'hF, 32'h8000_0300, 1'b0, dx(1, 0, K_MEM_WR, 4'h7));
    try(4'h8, 32'h8000_0100, 1'b0, dx(0, 0, K_NONE, 4'h0));
    try(4'h9, 32'h8000_0100, 1'b0, dx(0, 0, K_NONE, 4'h0));
    pcix = 1'b1;
    try(4'hC, 32'h0005_0000, 1'b0, dx(1, 0, K_SPLIT, 4'hC));
    try(4'hE, 32'h8000_0200, 1'b0, dx(1, 0, K_MRB, 4'hE));
    try(4'hF, 32'h8000_0300, 1'b0, dx(1, 0, K_MWB, 4'hF));
    try(4'h8, 32'h8000_0100, 1'b0, dx(1, 0, K_MRB, 4'hE));
    try(4'h9, 32'h8000_0100, 1'b0, dx(1, 0, K_MWB, 4'hF));
    pcix = 1'b0;
  endtask : t_aliases
  logic [3:0] rsv [4] = '{4'h0, 4'h1, 4'h4, 4'h5};
  task automatic t_mem_io();
    try(4'h6, 32'h8FFF_FFFC, 1'b0, dx(1, 0, K_MEM_RD, 4'h6));
    try(4'h7, 32'h4000_0010, 1'b0, dx(0, 1, K_MEM_LOCAL, 4'h7));
    try(4'h6, 32'h2000_0000, 1'b0, dx(0, 0, K_NONE, 4'h0));
    try(4'h2, 32'h0000_1004, 1'b0, dx(1, 0, K_IO, 4'h2));
    try(4'h3, 32'h0000_0804, 1'b0, dx(0, 1, K_IO_LOCAL, 4'h3));
    try(4'h2, 32'h0000_3000, 1'b0, dx(0, 0, K_NONE, 4'h0));
    foreach (rsv[i]) try(rsv[i], 32'h8000_0000, 1'b1, dx(0, 0, K_NONE, 4'h0));
  endtask : t_mem_io
  task automatic t_dac();
    i_init.issue_dac(4'h6, 32'h0000_0001, 32'h0000_1000);
    chk_dec({5'b11101, K_MEM_RD, 4'h6});
    chk_addr(64'h0000_0001_0000_1000);
    try(4'h7, 32'h8000_0040, 1'b0, dx(1, 0, K_MEM_WR, 4'h7));
  endtask : t_dac
  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  initial begin
    #(25 * 3000);
    n_mismatch++;
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    pcix = 1'b0;
    sec = 8'h05;
    sub = 8'h09;
    m_b = 64'h0000_0000_8000_0000;
    m_l = 64'h0000_0001_8FFF_FFFF;
    io_b = 32'h0000_1000;
    io_l = 32'h0000_1FFF;
    cm_b = 32'h4000_0000;
    ci_b = 32'h0000_0800;
    repeat (4) @(posedge clk);
    #2;
    rstn = 1'b1;
    t_cfg_read();
    t_cfg_write();
    t_aliases();
    t_mem_io();
    t_dac();
    end_sim();
  end
endmodule : pcd_primary_cmd_decode_tb
